// ===== rtl/smps_pkg.sv
package smps_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] SMPS_IDX_SYNC_CTRL   = 12'h26f;
  localparam logic [11:0] SMPS_IDX_MON_CTRL    = 12'h270;
  localparam logic [11:0] SMPS_IDX_PERIOD0     = 12'h271;
  localparam logic [11:0] SMPS_IDX_PERIOD1     = 12'h272;
  localparam logic [11:0] SMPS_IDX_PERIOD2     = 12'h273;
  localparam logic [11:0] SMPS_IDX_RESULT_CTRL = 12'h274;
  localparam logic [11:0] SMPS_IDX_STATUS0     = 12'h275;
  localparam logic [11:0] SMPS_IDX_STATUS1     = 12'h276;
  localparam logic [11:0] SMPS_IDX_STATUS2     = 12'h277;
  localparam logic [11:0] SMPS_IDX_FRAME       = 12'h278;
  localparam logic [11:0] SMPS_IDX_SYSREF_CTRL = 12'h27f;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          SMPS_BIT_SYNC_EN     = 0;
  localparam int          SMPS_BIT_SYNC_NEXT   = 1;
  localparam int          SMPS_BIT_PEAK_EN     = 1;
  localparam int          SMPS_BIT_UPDATE      = 4;
  localparam int          SMPS_BIT_SYSREF_EN   = 0;
  localparam logic [7:0]  SMPS_RST_PERIOD0     = 8'h80;
  localparam logic [7:0]  SMPS_RST_PERIOD1     = 8'h00;
  localparam logic [7:0]  SMPS_RST_PERIOD2     = 8'h00;
  localparam logic [2:0]  SMPS_SEL_PEAK        = 3'h1;
  localparam logic [23:0] SMPS_PERIOD_ONE      = 24'h000001;
  localparam logic [7:0]  SMPS_FRAME_STEP      = 8'h01;

  // ----------------------------------------------------------------
  // Widths and types
  // ----------------------------------------------------------------
  localparam int SMPS_SAMPLE_W = 14;
  localparam int SMPS_RESULT_W = 20;

  typedef struct packed {
    logic        syncEnable;
    logic        syncNext;
    logic        peakEnable;
    logic        sysrefEnable;
    logic [2:0]  resultSelect;
    logic [23:0] period;
  } smps_cfg_t;

  typedef struct packed {
    logic [SMPS_RESULT_W-1:0] result;
    logic [7:0]               frameCount;
  } smps_status_t;

  typedef enum logic [1:0] {
    SMPS_BUS_IDLE = 2'b01,
    SMPS_BUS_RESP = 2'b10
  } smps_bus_state_t;

endpackage : smps_pkg

// ===== rtl/smps_peak_det.sv
`timescale 1ns/1ps
module smps_peak_det
  import smps_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     enable,
  input  wire logic                     restart,
  input  wire logic [SMPS_SAMPLE_W-1:0] sample,
  output logic      [SMPS_SAMPLE_W-1:0] peak
);

  logic [SMPS_SAMPLE_W-1:0] magnitude;
  logic [SMPS_SAMPLE_W-1:0] next_peak;

  // ----------------------------------------------------------------
  // Running peak of sample magnitude
  // ----------------------------------------------------------------

  // Absolute value; most negative code maps to its unsigned magnitude
  always_comb
  begin
    magnitude = sample[SMPS_SAMPLE_W-1] ? (~sample + 1'b1) : sample;
    next_peak = peak;
    if (!enable)
    begin
      next_peak = '0;
    end
    else if (restart)
    begin
      next_peak = magnitude;                   // New window starts here
    end
    else if (magnitude > peak)
    begin
      next_peak = magnitude;
    end
  end

  // Peak register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      peak <= '0;
    end
    else
    begin
      peak <= next_peak;
    end
  end

endmodule : smps_peak_det

// ===== rtl/smps_monitor.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module smps_monitor
  import smps_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [13:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [SMPS_SAMPLE_W-1:0] sampleIn,
  input  wire logic                     sysrefIn,
  output logic      [SMPS_RESULT_W-1:0] statusReadback,
  output logic                          syncPulse
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  smps_bus_state_t          busState;
  smps_bus_state_t          next_busState;
  logic [31:0]              next_prdata;
  logic                     next_pready;
  logic                     next_pslverr;

  smps_cfg_t                cfg;
  smps_cfg_t                next_cfg;
  logic [7:0]               period0;
  logic [7:0]               period1;
  logic [7:0]               period2;
  logic [7:0]               next_period0;
  logic [7:0]               next_period1;
  logic [7:0]               next_period2;
  logic                     updatePulse;
  logic                     next_updatePulse;

  logic [23:0]              periodCount;
  logic [23:0]              next_periodCount;
  logic [7:0]               frameCount;
  logic [7:0]               next_frameCount;
  logic [SMPS_RESULT_W-1:0] monitorResult;
  logic [SMPS_RESULT_W-1:0] next_monitorResult;
  smps_status_t             status;
  smps_status_t             next_status;
  logic                     sysrefPrev;
  logic [SMPS_RESULT_W-1:0] next_statusReadback;
  logic                     next_syncPulse;

  logic [SMPS_SAMPLE_W-1:0] peak;
  logic [11:0]              regIndex;
  logic                     addrAligned;
  logic                     addrMapped;
  logic                     writeDone;
  logic                     sysrefEdge;
  logic                     syncHit;
  logic                     periodExpire;
  logic                     restartPeak;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Word index and mapping check
  always_comb
  begin
    regIndex    = paddr[13:2];
    addrAligned = (paddr[1:0] == 2'h0);
    case (regIndex)
      SMPS_IDX_SYNC_CTRL, SMPS_IDX_MON_CTRL, SMPS_IDX_PERIOD0,
      SMPS_IDX_PERIOD1, SMPS_IDX_PERIOD2, SMPS_IDX_RESULT_CTRL,
      SMPS_IDX_STATUS0, SMPS_IDX_STATUS1, SMPS_IDX_STATUS2,
      SMPS_IDX_FRAME, SMPS_IDX_SYSREF_CTRL:
        addrMapped = addrAligned;
      default:
        addrMapped = 1'b0;
    endcase
  end

  // Write commits at the completing access edge only
  assign writeDone = psel && penable && pready && pwrite && addrMapped && pstrb[0];

  // ----------------------------------------------------------------
  // APB slave: one wait-free answer after setup
  // ----------------------------------------------------------------

  // Bus next state, read data and error
  always_comb
  begin
    next_busState = busState;
    next_prdata   = prdata;
    next_pready   = 1'b0;
    next_pslverr  = 1'b0;
    case (busState)
      SMPS_BUS_IDLE:
      begin
        if (psel && !penable)
        begin
          next_busState = SMPS_BUS_RESP;
          next_pready   = 1'b1;
          next_pslverr  = !addrMapped;
          next_prdata   = 32'h0000_0000;
          if (!pwrite && addrMapped)
          begin
            case (regIndex)
              SMPS_IDX_SYNC_CTRL:
                next_prdata[1:0] = {cfg.syncNext, cfg.syncEnable};
              SMPS_IDX_MON_CTRL:
                next_prdata[SMPS_BIT_PEAK_EN] = cfg.peakEnable;
              SMPS_IDX_PERIOD0:
                next_prdata[7:0] = period0;
              SMPS_IDX_PERIOD1:
                next_prdata[7:0] = period1;
              SMPS_IDX_PERIOD2:
                next_prdata[7:0] = period2;
              SMPS_IDX_RESULT_CTRL:
                next_prdata[2:0] = cfg.resultSelect;    // Update bit reads zero
              SMPS_IDX_STATUS0:
                next_prdata[7:0] = status.result[7:0];
              SMPS_IDX_STATUS1:
                next_prdata[7:0] = status.result[15:8];
              SMPS_IDX_STATUS2:
                next_prdata[3:0] = status.result[19:16];
              SMPS_IDX_FRAME:
                next_prdata[7:0] = status.frameCount;
              SMPS_IDX_SYSREF_CTRL:
                next_prdata[SMPS_BIT_SYSREF_EN] = cfg.sysrefEnable;
              default:
                next_prdata = 32'h0000_0000;
            endcase
          end
        end
      end
      SMPS_BUS_RESP:
      begin
        next_busState = SMPS_BUS_IDLE;
      end
      default:
      begin
        next_busState = SMPS_BUS_IDLE;
      end
    endcase
  end

  // Bus registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busState <= SMPS_BUS_IDLE;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end
    else
    begin
      busState <= next_busState;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  // SYSREF edge detect and synchronization qualifier
  assign sysrefEdge = sysrefIn && !sysrefPrev;
  assign syncHit    = sysrefEdge && cfg.sysrefEnable && cfg.syncEnable;

  // Register writes and hardware clear of the one-shot arm
  always_comb
  begin
    next_cfg         = cfg;
    next_period0     = period0;
    next_period1     = period1;
    next_period2     = period2;
    next_updatePulse = 1'b0;
    if (syncHit && cfg.syncNext)
    begin
      next_cfg.syncEnable = 1'b0;
    end
    if (writeDone)
    begin
      case (regIndex)
        SMPS_IDX_SYNC_CTRL:
        begin
          next_cfg.syncEnable = pwdata[SMPS_BIT_SYNC_EN];   // Rearm beats clear
          next_cfg.syncNext   = pwdata[SMPS_BIT_SYNC_NEXT];
        end
        SMPS_IDX_MON_CTRL:
          next_cfg.peakEnable = pwdata[SMPS_BIT_PEAK_EN];
        SMPS_IDX_PERIOD0:
          next_period0 = pwdata[7:0];
        SMPS_IDX_PERIOD1:
          next_period1 = pwdata[7:0];
        SMPS_IDX_PERIOD2:
          next_period2 = pwdata[7:0];
        SMPS_IDX_RESULT_CTRL:
        begin
          next_cfg.resultSelect = pwdata[2:0];
          next_updatePulse      = pwdata[SMPS_BIT_UPDATE];
        end
        SMPS_IDX_SYSREF_CTRL:
          next_cfg.sysrefEnable = pwdata[SMPS_BIT_SYSREF_EN];
        default:
          next_cfg = next_cfg;
      endcase
    end
    next_cfg.period = {next_period2, next_period1, next_period0};
  end

  // Configuration flops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg.syncEnable   <= 1'b0;
      cfg.syncNext     <= 1'b0;
      cfg.peakEnable   <= 1'b0;
      cfg.sysrefEnable <= 1'b0;
      cfg.resultSelect <= SMPS_SEL_PEAK;
      cfg.period       <= {SMPS_RST_PERIOD2, SMPS_RST_PERIOD1, SMPS_RST_PERIOD0};
      period0          <= SMPS_RST_PERIOD0;
      period1          <= SMPS_RST_PERIOD1;
      period2          <= SMPS_RST_PERIOD2;
      updatePulse      <= 1'b0;
    end
    else
    begin
      cfg         <= next_cfg;
      period0     <= next_period0;
      period1     <= next_period1;
      period2     <= next_period2;
      updatePulse <= next_updatePulse;
    end
  end

  // ----------------------------------------------------------------
  // Period counter, frame counter and result capture
  // ----------------------------------------------------------------

  // Expiry after period sys_clk cycles; 0 or 1 expires every cycle
  assign periodExpire = (cfg.period <= SMPS_PERIOD_ONE) ||
                        (periodCount >= cfg.period - SMPS_PERIOD_ONE);
  assign restartPeak  = periodExpire || syncHit;

  // Measurement window state
  always_comb
  begin
    next_periodCount   = periodCount + SMPS_PERIOD_ONE;
    next_frameCount    = frameCount;
    next_monitorResult = monitorResult;
    next_status        = status;
    if (syncHit)
    begin
      next_periodCount = '0;
    end
    else if (periodExpire)
    begin
      next_periodCount   = '0;
      next_frameCount    = frameCount + SMPS_FRAME_STEP;
      next_monitorResult = {{(SMPS_RESULT_W-SMPS_SAMPLE_W){1'b0}}, peak};
    end
    if (updatePulse)
    begin
      next_status.result     = monitorResult;
      next_status.frameCount = frameCount;
    end
  end

  // Readback routing by result selection
  always_comb
  begin
    next_statusReadback = '0;
    if (cfg.resultSelect == SMPS_SEL_PEAK)
    begin
      next_statusReadback = status.result;
    end
    next_syncPulse = syncHit;
  end

  // Measurement flops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      periodCount    <= '0;
      frameCount     <= '0;
      monitorResult  <= '0;
      status         <= '0;
      sysrefPrev     <= 1'b0;
      statusReadback <= '0;
      syncPulse      <= 1'b0;
    end
    else
    begin
      periodCount    <= next_periodCount;
      frameCount     <= next_frameCount;
      monitorResult  <= next_monitorResult;
      status         <= next_status;
      sysrefPrev     <= sysrefIn;
      statusReadback <= next_statusReadback;
      syncPulse      <= next_syncPulse;
    end
  end

  // ----------------------------------------------------------------
  // Peak detector
  // ----------------------------------------------------------------

  // Restarted on each window boundary or sync
  smps_peak_det u_peak (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enable  (cfg.peakEnable),
    .restart (restartPeak),
    .sample  (sampleIn),
    .peak    (peak)
  );

endmodule : smps_monitor

// ===== verification/smps_monitor_chk.sv
`timescale 1ns/1ps
module smps_monitor_chk
  import smps_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [13:0] sampleIn,
  input wire logic        sysrefIn,
  input wire logic [19:0] statusReadback,
  input wire logic        syncPulse
);
  logic [1:0]  syncSh;
  logic [1:0]  next_syncSh;
  logic        sreSh;
  logic        next_sreSh;
  logic        seen;
  logic        next_seen;
  logic [2:0]  selSh;
  logic [2:0]  next_selSh;
  logic [3:0]  since;
  logic [3:0]  next_since;
  logic        wrAcc;
  logic [11:0] idx;

  // Completed register writes
  assign idx   = paddr[13:2];
  assign wrAcc = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

  // Shadow of sync, SYSREF enable and select settings
  always_comb
  begin
    next_syncSh = syncSh;
    next_sreSh  = sreSh;
    next_selSh  = selSh;
    next_seen   = seen || syncPulse;
    next_since  = (since == 4'hf) ? since : since + 4'h1;
    if (syncPulse && syncSh[1])
      next_syncSh[0] = 1'b0;
    if (wrAcc && idx == SMPS_IDX_SYNC_CTRL)
    begin
      next_syncSh = pwdata[1:0];
      next_seen   = 1'b0;
    end
    if (wrAcc && idx == SMPS_IDX_SYSREF_CTRL)
      next_sreSh = pwdata[0];
    if (wrAcc && idx == SMPS_IDX_RESULT_CTRL)
    begin
      next_selSh = pwdata[2:0];
      next_since = 4'h0;
    end
  end

  // Shadow registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      {syncSh, sreSh, selSh, seen, since} <= {2'h0, 1'b0, 3'h1, 1'b0, 4'hf};
    else
      {syncSh, sreSh, selSh, seen, since} <=
        {next_syncSh, next_sreSh, next_selSh, next_seen, next_since};
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_rdy;
    psel && !penable && !pready |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready not a single cycle");

  property p_err;
    pready && paddr[1:0] != 2'h0 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unaligned access not refused");

  property p_en;
    syncPulse |-> syncSh[0] && sreSh;
  endproperty
  a_en: assert property (p_en) else $error("sync while disabled");

  property p_once;
    syncPulse && syncSh[1] |-> !seen;
  endproperty
  a_once: assert property (p_once) else $error("second one-shot sync");

  property p_edge;
    syncPulse |-> $past(sysrefIn) && !$past(sysrefIn, 2);
  endproperty
  a_edge: assert property (p_edge) else $error("sync without SYSREF edge");

  property p_gap;
    syncPulse |=> !syncPulse;
  endproperty
  a_gap: assert property (p_gap) else $error("sync pulse too long");

  property p_sel;
    statusReadback != 20'h0 |-> $past(selSh) == SMPS_SEL_PEAK;
  endproperty
  a_sel: assert property (p_sel) else $error("readback with other select");

  property p_hold;
    !$stable(statusReadback) |-> since < 4'h3;
  endproperty
  a_hold: assert property (p_hold) else $error("readback moved without update");
endmodule : smps_monitor_chk

bind smps_monitor smps_monitor_chk u_smps_monitor_chk (.*);

// ===== verification/smps_monitor_bench.sv
`timescale 1ns/1ps
module smps_monitor_bench
  import smps_pkg::*;
();
  logic        sys_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [13:0] sampleIn;
  logic        sysrefIn;
  logic [19:0] statusReadback;
  logic        syncPulse;
  int          errors = 0;
  int          n_checks = 0;
  int          nPulse = 0;

  smps_monitor u_smps_monitor (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleIn(sampleIn), .sysrefIn(sysrefIn),
    .statusReadback(statusReadback), .syncPulse(syncPulse)
  );

  // Clock and sync pulse counter
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (syncPulse === 1'b1)
      nPulse++;

  task complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [13:0] ad, input logic [7:0] wd,
           input logic sb, output logic [31:0] rd, output logic er);
    int n;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= {24'h000000, wd};
    pstrb  <= {3'h0, sb};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
      chk("pready", 32'h0, 32'h1);
  endtask : apb

  task wreg(input logic [11:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, {ix, 2'h0}, d, 1'b1, r, e);
  endtask : wreg

  task rreg(input string nm, input logic [11:0] ix, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, {ix, 2'h0}, 8'h00, 1'b1, r, e);
    chk(nm, r, {24'h000000, x});
  endtask : rreg

  // SYSREF pulses every 8 cycles, a multiple of the period
  task syncs(input string nm, input int k, input logic [31:0] x);
    int p0;
    p0 = nPulse;
    repeat (k)
    begin
      sysrefIn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sysrefIn <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    chk(nm, 32'(nPulse - p0), x);
  endtask : syncs

  task t_reset();
    rreg("sync", SMPS_IDX_SYNC_CTRL, 8'h00);
    rreg("mctl", SMPS_IDX_MON_CTRL, 8'h00);
    rreg("per0", SMPS_IDX_PERIOD0, 8'h80);
    rreg("per1", SMPS_IDX_PERIOD1, 8'h00);
    rreg("per2", SMPS_IDX_PERIOD2, 8'h00);
    rreg("rctl", SMPS_IDX_RESULT_CTRL, 8'h01);
    rreg("st0", SMPS_IDX_STATUS0, 8'h00);
    rreg("st2", SMPS_IDX_STATUS2, 8'h00);
    rreg("frm", SMPS_IDX_FRAME, 8'h00);
    rreg("sref", SMPS_IDX_SYSREF_CTRL, 8'h00);
    chk("rdbk rst", {12'h0, statusReadback}, 32'h0);
  endtask : t_reset

  task t_bus();
    logic [31:0] r;
    logic        e;
    apb(1'b0, {12'h280, 2'h0}, 8'h00, 1'b1, r, e);
    chk("unmapped", {e, r[30:0]}, 32'h80000000);
    apb(1'b1, {SMPS_IDX_PERIOD0, 2'h1}, 8'h44, 1'b1, r, e);
    chk("unaligned", {31'h0, e}, 32'h1);
    apb(1'b1, {SMPS_IDX_PERIOD1, 2'h0}, 8'h56, 1'b0, r, e);
    rreg("per0 kept", SMPS_IDX_PERIOD0, 8'h80);
    rreg("per1 kept", SMPS_IDX_PERIOD1, 8'h00);
    wreg(SMPS_IDX_STATUS0, 8'hff);
    rreg("ro", SMPS_IDX_STATUS0, 8'h00);
  endtask : t_bus

  task t_period();
    wreg(SMPS_IDX_PERIOD0, 8'h12);
    wreg(SMPS_IDX_PERIOD1, 8'h34);
    wreg(SMPS_IDX_PERIOD2, 8'h56);
    rreg("p0", SMPS_IDX_PERIOD0, 8'h12);
    rreg("p1", SMPS_IDX_PERIOD1, 8'h34);
    rreg("p2", SMPS_IDX_PERIOD2, 8'h56);
    wreg(SMPS_IDX_PERIOD2, 8'h00);
    wreg(SMPS_IDX_PERIOD1, 8'h00);
    wreg(SMPS_IDX_PERIOD0, 8'h08);
    wreg(SMPS_IDX_RESULT_CTRL, 8'h11);
    rreg("upd", SMPS_IDX_RESULT_CTRL, 8'h01);
  endtask : t_period

  // Constant sample of magnitude 0x12c, period 8
  task t_measure();
    logic [31:0] f1;
    logic [31:0] f2;
    logic        e;
    sampleIn <= 14'h3ed4;
    wreg(SMPS_IDX_MON_CTRL, 8'h02);
    repeat (20) @(posedge sys_clk);
    wreg(SMPS_IDX_RESULT_CTRL, 8'h11);
    apb(1'b0, {SMPS_IDX_FRAME, 2'h0}, 8'h00, 1'b1, f1, e);
    rreg("res0", SMPS_IDX_STATUS0, 8'h2c);
    rreg("res1", SMPS_IDX_STATUS1, 8'h01);
    rreg("res2", SMPS_IDX_STATUS2, 8'h00);
    repeat (65) @(posedge sys_clk);
    wreg(SMPS_IDX_RESULT_CTRL, 8'h11);
    apb(1'b0, {SMPS_IDX_FRAME, 2'h0}, 8'h00, 1'b1, f2, e);
    chk("frames", {24'h0, f2[7:0] - f1[7:0]}, 32'h0000000a);
    chk("rdbk", {12'h0, statusReadback}, 32'h0000012c);
    wreg(SMPS_IDX_RESULT_CTRL, 8'h02);
    repeat (3) @(posedge sys_clk);
    chk("rdbk sel", {12'h0, statusReadback}, 32'h0);
    wreg(SMPS_IDX_RESULT_CTRL, 8'h01);
    wreg(SMPS_IDX_MON_CTRL, 8'h00);
    repeat (20) @(posedge sys_clk);
    wreg(SMPS_IDX_RESULT_CTRL, 8'h11);
    rreg("off0", SMPS_IDX_STATUS0, 8'h00);
    rreg("off1", SMPS_IDX_STATUS1, 8'h00);
  endtask : t_measure

  task t_sync();
    wreg(SMPS_IDX_SYNC_CTRL, 8'h01);
    syncs("no input", 2, 32'h0);
    wreg(SMPS_IDX_SYSREF_CTRL, 8'h01);
    syncs("cont", 2, 32'h2);
    wreg(SMPS_IDX_SYNC_CTRL, 8'h03);
    syncs("once", 3, 32'h1);
    rreg("cleared", SMPS_IDX_SYNC_CTRL, 8'h02);
    wreg(SMPS_IDX_SYNC_CTRL, 8'h02);
    syncs("off", 2, 32'h0);
  endtask : t_sync

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    sampleIn = 14'h0000;
    sysrefIn = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_bus();
    t_period();
    t_measure();
    t_sync();
    complete_run();
  end
endmodule : smps_monitor_bench
